// file: core/hppc_top.sv
// Hub port power configuration bank with AHB-Lite register access
`timescale 1ns/1ns
`include "hppc_defines.svh"

module hppc_top (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Hub state
  input  wire logic                  self_powered,
  input  wire logic [3:1]            sp_port_disable,
  input  wire logic [1:0]            strap_port_disable,
  // Descriptor values
  output hppc_pkg::hppc_desc_type    desc
);

  // Bank state
  hppc_pkg::hppc_state_type state_r;
  hppc_pkg::hppc_state_type state_nxt;
  hppc_pkg::hppc_wr_type    wr_r;
  hppc_pkg::hppc_wr_type    wr_nxt;
  hppc_pkg::hppc_desc_type  desc_nxt;
  logic [3:1]               bus_powered_port_disable_r;
  logic [7:0]               self_powered_max_power_r;
  logic [7:0]               bus_powered_max_power_r;
  logic [7:0]               self_powered_controller_current_r;
  logic [7:0]               bus_powered_controller_current_r;
  logic [7:0]               port_power_good_delay_r;
  logic                     use_default_r;
  logic [1:0]               strap_r;
  logic [31:0]              hrdata_nxt;

  // Count of set bits in a port enable mask
  function automatic logic [1:0] hppc_count(input logic [3:1] m);
    hppc_count = 2'(m[1]) + 2'(m[2]) + 2'(m[3]);
  endfunction : hppc_count

  // Strap value to disable mask
  function automatic logic [3:1] hppc_strap_mask(input logic [1:0] s);
    case (s)
      2'h0:    hppc_strap_mask = 3'h0;
      2'h1:    hppc_strap_mask = 3'h4;
      2'h2:    hppc_strap_mask = 3'h6;
      default: hppc_strap_mask = 3'h7;
    endcase
  endfunction : hppc_strap_mask

  // Address phase decode
  wire        addr_ok   = hsel && hready && htrans[1];
  wire        addr_hit  = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
  wire [7:0]  addr_idx  = haddr[9:2];
  wire        rd_take   = addr_ok && !hwrite;
  wire        wr_take   = addr_ok && hwrite;
  wire        wr_do     = wr_r.valid;
  wire [7:0]  wr_byte   = hwdata[7:0];

  // Write strobes per register
  wire we_bp_dis   = wr_do && wr_r.index == `HPPC_IDX_BP_DISABLE;
  wire we_sp_pwr   = wr_do && wr_r.index == `HPPC_IDX_SP_MAX_PWR;
  wire we_bp_pwr   = wr_do && wr_r.index == `HPPC_IDX_BP_MAX_PWR;
  wire we_sp_cur   = wr_do && wr_r.index == `HPPC_IDX_SP_CTRL_CUR;
  wire we_bp_cur   = wr_do && wr_r.index == `HPPC_IDX_BP_CTRL_CUR;
  wire we_pwr_good = wr_do && wr_r.index == `HPPC_IDX_PWR_GOOD;
  wire we_control  = wr_do && wr_r.index == `HPPC_IDX_CONTROL;

  // Values as seen after a write in flight lands
  wire [3:1] bp_dis_v   = we_bp_dis ? wr_byte[`HPPC_DIS_MSB:`HPPC_DIS_LSB] : bus_powered_port_disable_r;
  wire [7:0] sp_pwr_v   = we_sp_pwr ? wr_byte : self_powered_max_power_r;
  wire [7:0] bp_pwr_v   = we_bp_pwr ? wr_byte : bus_powered_max_power_r;
  wire [7:0] sp_cur_v   = we_sp_cur ? wr_byte : self_powered_controller_current_r;
  wire [7:0] bp_cur_v   = we_bp_cur ? wr_byte : bus_powered_controller_current_r;
  wire [7:0] pwr_good_v = we_pwr_good ? wr_byte : port_power_good_delay_r;
  wire       default_v  = we_control ? wr_byte[`HPPC_CTL_DEFAULT_BIT] : use_default_r;

  wire [3:1] strap_mask = hppc_strap_mask(strap_r);
  wire [3:1] mode_mask  = self_powered ? sp_port_disable : bp_dis_v;
  wire [3:1] off_mask   = default_v ? strap_mask : mode_mask;
  wire [3:1] on_mask    = ~off_mask;

  wire [5:0] port_num_v;
  genvar g;
  generate
    for (g = 1; g <= 3; g++) begin : g_num
      wire [3:1] below = on_mask & 3'((4'h1 << g) - 4'h1);
      assign port_num_v[2*g-1 -: 2] = on_mask[g] ? hppc_count(below) : 2'h0;
    end
  endgenerate

  wire [1:0] port_count_v = hppc_count(on_mask);

  wire [7:0] max_power_v  = self_powered ? sp_pwr_v : bp_pwr_v;
  wire [7:0] ctrl_cur_v   = self_powered ? sp_cur_v : bp_cur_v;

  always_comb begin
    desc_nxt               = desc;
    desc_nxt.port_off      = off_mask;
    desc_nxt.port_count    = port_count_v;
    desc_nxt.port_num      = port_num_v;
    desc_nxt.max_power     = max_power_v;
    desc_nxt.ctrl_current  = ctrl_cur_v;
    desc_nxt.power_on_time = pwr_good_v;
  end

  // Status word
  wire [31:0] status_word = {
    18'h0,
    port_num_v,
    2'h0,
    port_count_v,
    2'h0,
    default_v,
    self_powered
  };

  // Read mux, reserved bits zero
  always_comb begin
    hrdata_nxt = 32'h0;
    if (addr_hit) begin
      case (addr_idx)
        `HPPC_IDX_BP_DISABLE:  hrdata_nxt = {28'h0, bp_dis_v, 1'b0};
        `HPPC_IDX_SP_MAX_PWR:  hrdata_nxt = {24'h0, sp_pwr_v};
        `HPPC_IDX_BP_MAX_PWR:  hrdata_nxt = {24'h0, bp_pwr_v};
        `HPPC_IDX_SP_CTRL_CUR: hrdata_nxt = {24'h0, sp_cur_v};
        `HPPC_IDX_BP_CTRL_CUR: hrdata_nxt = {24'h0, bp_cur_v};
        `HPPC_IDX_PWR_GOOD:    hrdata_nxt = {24'h0, pwr_good_v};
        `HPPC_IDX_CONTROL:     hrdata_nxt = {31'h0, default_v};
        `HPPC_IDX_STATUS:      hrdata_nxt = status_word;
        default:               hrdata_nxt = 32'h0;
      endcase
    end
  end

  // Write capture for data phase
  always_comb begin
    wr_nxt       = '0;
    wr_nxt.valid = wr_take && addr_hit;
    wr_nxt.index = addr_idx;
  end

  // Straps caught once after reset
  always_comb begin
    case (state_r)
      hppc_pkg::HPPC_ST_STRAP: state_nxt = hppc_pkg::HPPC_ST_RUN;
      hppc_pkg::HPPC_ST_RUN:   state_nxt = hppc_pkg::HPPC_ST_RUN;
      default:                 state_nxt = hppc_pkg::HPPC_ST_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= hppc_pkg::HPPC_ST_STRAP;
      strap_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == hppc_pkg::HPPC_ST_STRAP) begin
        strap_r <= strap_port_disable;
      end
    end
  end

  // Bus response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_r      <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_r      <= wr_nxt;
      if (rd_take) begin
        hrdata <= hrdata_nxt;
      end
    end
  end

  // Register storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_powered_port_disable_r        <= `HPPC_RST_BP_DISABLE;
      self_powered_max_power_r          <= `HPPC_RST_SP_MAX_PWR;
      bus_powered_max_power_r           <= `HPPC_RST_BP_MAX_PWR;
      self_powered_controller_current_r <= `HPPC_RST_CTRL_CUR;
      bus_powered_controller_current_r  <= `HPPC_RST_CTRL_CUR;
      port_power_good_delay_r           <= `HPPC_RST_PWR_GOOD;
      use_default_r                     <= `HPPC_RST_CONTROL;
    end else begin
      bus_powered_port_disable_r        <= bp_dis_v;
      self_powered_max_power_r          <= sp_pwr_v;
      bus_powered_max_power_r           <= bp_pwr_v;
      self_powered_controller_current_r <= sp_cur_v;
      bus_powered_controller_current_r  <= bp_cur_v;
      port_power_good_delay_r           <= pwr_good_v;
      use_default_r                     <= default_v;
    end
  end

  // Descriptor output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc <= '0;
    end else begin
      desc <= desc_nxt;
    end
  end

endmodule : hppc_top

// file: core/hppc_defines.svh
// Offsets, field positions, reset values and timing units for the hub port power bank
// Function
// - A set disable bit marks its port disabled; a clear bit leaves it available.
// - Disable bits 3, 2, 1 steer physical ports 3, 2, 1; others reserved.
// - A disabled port stays off; the host can neither enable nor enumerate it.
// - Any combination may be disabled; report enabled count and renumber active ports.
// - With internal defaults, the two-bit strap value picks the disabled ports.
// - Maximum power bytes give whole-board draw, one count per 2 mA.
// - Both controller current bytes reset to fifty, meaning 100 mA.
// - Power-on time byte gives port power-good delay in 2 ms units.
`ifndef HPPC_DEFINES_SVH
`define HPPC_DEFINES_SVH

// Register indices; byte address is four times the index
`define HPPC_IDX_BP_DISABLE   8'he9
`define HPPC_IDX_SP_MAX_PWR   8'hea
`define HPPC_IDX_BP_MAX_PWR   8'heb
`define HPPC_IDX_SP_CTRL_CUR  8'hec
`define HPPC_IDX_BP_CTRL_CUR  8'hed
`define HPPC_IDX_PWR_GOOD     8'hee
`define HPPC_IDX_CONTROL      8'hf8
`define HPPC_IDX_STATUS       8'hf9

// Field positions
`define HPPC_DIS_LSB          1
`define HPPC_DIS_MSB          3
`define HPPC_CTL_DEFAULT_BIT  0
`define HPPC_STS_SELF_BIT     0
`define HPPC_STS_DEFAULT_BIT  1
`define HPPC_STS_COUNT_LSB    4
`define HPPC_STS_MAP_LSB      8

// Reset values
`define HPPC_RST_BP_DISABLE   3'h0
`define HPPC_RST_SP_MAX_PWR   8'h00
`define HPPC_RST_BP_MAX_PWR   8'h00
`define HPPC_RST_CTRL_CUR     8'h32
`define HPPC_RST_PWR_GOOD     8'h00
`define HPPC_RST_CONTROL      1'h0

// Units of the reported values
`define HPPC_CURRENT_UNIT_MA  2
`define HPPC_TIME_UNIT_MS     2
`define HPPC_USB_LIMIT_MA     100

`endif

// file: core/hppc_pkg.sv
// Types shared by the hub port power configuration bank
package hppc_pkg;

  typedef enum logic [0:0] {
    HPPC_ST_STRAP,
    HPPC_ST_RUN
  } hppc_state_type;

  // Values handed to the descriptor builder
  typedef struct packed {
    logic [3:1] port_off;
    logic [1:0] port_count;
    logic [5:0] port_num;
    logic [7:0] max_power;
    logic [7:0] ctrl_current;
    logic [7:0] power_on_time;
  } hppc_desc_type;

  // Latched write of the data phase
  typedef struct packed {
    logic       valid;
    logic [7:0] index;
  } hppc_wr_type;

endpackage : hppc_pkg

// file: tb/hppc_chk_assertions.sv
// Assertion checker for the hub port power bank
`timescale 1ns/1ns
`include "hppc_defines.svh"
module hppc_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Hub side
  input wire logic self_powered,
  input wire hppc_pkg::hppc_desc_type desc
);
  logic [1:0] up_r;
  wire  [3:1] unnum_w = {desc.port_num[5:4] == 2'h0, desc.port_num[3:2] == 2'h0, desc.port_num[1:0] == 2'h0};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr(logic [7:0] i); hsel && hready && htrans[1] && hwrite && haddr == {22'h0, i, 2'h0}; endsequence
  sequence s_upd(logic [7:0] i, logic m); s_wr(i) ##0 (self_powered == m)[*4]; endsequence
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready");
  property p_off_num; up_r[1] |-> desc.port_off == unnum_w; endproperty
  a_off_num: assert property (p_off_num) else $error("disabled port numbered");
  property p_count; up_r[1] |-> desc.port_count == 2'(3 - $countones(desc.port_off)); endproperty
  a_count: assert property (p_count) else $error("port count wrong");
  property p_num; up_r[1] |-> (desc.port_off[1] || desc.port_num[1:0] == 2'h1) &&
    (desc.port_off[3] || desc.port_num[5:4] == desc.port_count); endproperty
  a_num: assert property (p_num) else $error("ports not renumbered");
  property p_mp_sp; s_upd(`HPPC_IDX_SP_MAX_PWR, 1'b1) |-> desc.max_power == $past(hwdata[7:0], 2); endproperty
  a_mp_sp: assert property (p_mp_sp) else $error("self max power wrong");
  property p_mp_bp; s_upd(`HPPC_IDX_BP_MAX_PWR, 1'b0) |-> desc.max_power == $past(hwdata[7:0], 2); endproperty
  a_mp_bp: assert property (p_mp_bp) else $error("bus max power wrong");
  property p_pwr; s_wr(`HPPC_IDX_PWR_GOOD) ##3 1'b1 |-> desc.power_on_time == $past(hwdata[7:0], 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power-on time wrong");
  property p_rst; up_r == 2'h1 |-> desc.ctrl_current == 8'h32; endproperty
  a_rst: assert property (p_rst) else $error("current reset wrong");
  property p_rsvd; !hwrite && hsel && hready && htrans[1] && haddr == {22'h0, `HPPC_IDX_BP_DISABLE, 2'h0} |=>
    hrdata[31:4] == 28'h0 && !hrdata[0]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule : hppc_chk
bind hppc_top hppc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .self_powered, .desc);

// file: tb/hppc_host.sv
// Host model that times port access from the reported delay
`timescale 1ns/1ns
module hppc_host (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Descriptor and port power request
  input wire hppc_pkg::hppc_desc_type desc,
  input wire logic power_req,
  output logic access_ok
);
  logic [8:0] wait_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wait_r <= 9'h0;
    else if (power_req) wait_r <= {desc.power_on_time, 1'b0};
    else if (wait_r != 9'h0) wait_r <= wait_r - 9'h1;
  end
  assign access_ok = (wait_r == 9'h0);
endmodule : hppc_host

// file: tb/tb.sv
// Testbench of the hub port power bank
`timescale 1ns/1ns
`include "hppc_defines.svh"
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, self_powered, power_req, access_ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, strap_port_disable;
  logic [2:0] hsize;
  logic [3:1] sp_port_disable;
  hppc_pkg::hppc_desc_type desc;
  int failures, compares, n;
  logic [7:0] wv [6];
  assign hready = hreadyout;
  hppc_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .self_powered, .sp_port_disable, .strap_port_disable, .desc);
  hppc_host u_host (.hclk, .hresetn, .desc, .power_req, .access_ok);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic view;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask : view
  function automatic logic [10:0] ports(input logic [3:1] m);
    logic [1:0] c;
    logic [5:0] num;
    c = 2'h0;
    num = 6'h0;
    for (int p = 1; p <= 3; p++) begin
      if (!m[p]) begin
        c++;
        num[2*p-2 +: 2] = c;
      end
    end
    return {m, c, num};
  endfunction : ports
  initial begin
    #40000;
    failures++;
    complete_run;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, power_req, self_powered} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    strap_port_disable = 2'h2;
    sp_port_disable = 3'h2;
    wv = '{8'hff, 8'h30, 8'hc8, 8'h28, 8'h40, 8'h05};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, `HPPC_IDX_BP_DISABLE + 8'(i), 32'h0);
      check(rd, (i == 3 || i == 4) ? 32'h32 : 32'h0);
    end
    for (int i = 0; i < 6; i++) bus(1'b1, `HPPC_IDX_BP_DISABLE + 8'(i), {24'hffffff, wv[i]});
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, `HPPC_IDX_BP_DISABLE + 8'(i), 32'h0);
      check(rd, (i == 0) ? 32'h0e : {24'h0, wv[i]});
    end
    bus(1'b1, 8'h40, 32'h5a);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    view;
    check({desc.max_power, desc.ctrl_current, desc.power_on_time}, {8'hc8, 8'h40, 8'h05});
    check(desc.port_off, 3'h7);
    @(posedge hclk) self_powered <= 1'b1;
    bus(1'b1, `HPPC_IDX_SP_MAX_PWR, 32'h31);
    view;
    check({desc.port_off, desc.max_power, desc.ctrl_current}, {3'h2, 8'h31, 8'h28});
    @(posedge hclk) self_powered <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, `HPPC_IDX_BP_DISABLE, {28'h0, 3'(m), 1'b0});
      view;
      check({desc.port_off, desc.port_count, desc.port_num}, ports(3'(m)));
    end
    bus(1'b1, `HPPC_IDX_CONTROL, 32'h1);
    view;
    check(desc.port_off, 3'h6);
    bus(1'b0, `HPPC_IDX_CONTROL, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, `HPPC_IDX_STATUS, 32'h0);
    check(rd, 32'h112);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap_port_disable <= 2'h3;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `HPPC_IDX_BP_DISABLE, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `HPPC_IDX_CONTROL, 32'h1);
    view;
    check(desc.port_off, 3'h7);
    bus(1'b1, `HPPC_IDX_PWR_GOOD, 32'h05);
    view;
    @(posedge hclk) power_req <= 1'b1;
    @(posedge hclk) power_req <= 1'b0;
    n = 0;
    @(negedge hclk);
    while (access_ok !== 1'b1) begin
      @(negedge hclk);
      n++;
    end
    check(n, 10);
    complete_run;
  end
endmodule : tb
